// [bench/pac_core_asserts.sv]
// port checker for the alarm core
`timescale 1ns/1ps
module pac_core_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic cj_active,
  input wire logic input_fault,
  input wire logic adc_fail,
  input wire logic [15:0] exp_set_addr,
  input wire logic [15:0] exp_ctl_addr,
  input wire logic [15:0] on_delay,
  input wire logic signed [31:0] pv_limit_hh,
  input wire logic signed [31:0] pv_limit_ll,
  input wire logic signed [31:0] process_value,
  input wire logic [3:0] pv_alarm,
  input wire logic unit_error_indicator,
  input wire logic cold_junction_error,
  input wire logic input_error,
  input wire logic converter_error,
  input wire logic period_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // restart clears the timer, so spacing is only judged between restarts
  a_tick_gap: assert property (disable iff (rst || restart) period_tick |=> !period_tick [*8])
    else $error("tick too soon");
  a_pv_hold: assert property (!period_tick |-> $stable(process_value))
    else $error("value moved off tick");
  a_alarm_hold: assert property (!period_tick |-> $stable(pv_alarm))
    else $error("alarm moved off tick");
  a_cj_flag: assert property (1'b1 |=> cold_junction_error == !$past(cj_active))
    else $error("cold junction flag wrong");
  a_in_err: assert property (1'b1 |=> input_error == $past(input_fault))
    else $error("input error wrong");
  a_odd_addr: assert property ((exp_set_addr[0] | exp_ctl_addr[0]) |-> ##[0:1] unit_error_indicator)
    else $error("odd address not flagged");
  a_adc_err: assert property (adc_fail |-> ##[0:2] converter_error)
    else $error("converter error missing");
  a_high_on: assert property (period_tick && on_delay == 16'h0000
    && process_value > $past(pv_limit_hh) |-> pv_alarm[0])
    else $error("upper alarm missing");
  a_low_on: assert property (period_tick && on_delay == 16'h0000
    && process_value < $past(pv_limit_ll) |-> pv_alarm[3])
    else $error("lower alarm missing");
  c_high: cover property (period_tick && pv_alarm[1]);
  c_low: cover property (period_tick && pv_alarm[2]);
  c_err: cover property (unit_error_indicator);
endmodule : pac_core_asserts
bind pac_core pac_core_asserts u_chk (.core_clk, .rst, .restart, .cj_active, .input_fault,
  .adc_fail, .exp_set_addr, .exp_ctl_addr, .on_delay, .pv_limit_hh, .pv_limit_ll,
  .process_value, .pv_alarm, .unit_error_indicator, .cold_junction_error, .input_error,
  .converter_error, .period_tick);

// [bench/pac_core_bench.sv]
// self-checking bench for the alarm core
`timescale 1ns/1ps
module pac_core_bench;
  logic core_clk = 1'b0, rst = 1'b1, restart = 1'b0, adc_fail = 1'b0, input_fault = 1'b0;
  logic cj_active = 1'b1, init_hires = 1'b0, init_sqrt_en = 1'b0, odd_req = 1'b0;
  logic [2:0] init_avg_log2 = 3'h0;
  logic [15:0] span_gain = 16'h0000, hysteresis = 16'h0000, on_delay = 16'h0000;
  logic [15:0] off_delay = 16'h0000, exp_set_addr, exp_ctl_addr;
  logic signed [31:0] smin = 32'h00000000, soff = 32'h00000005, pv, rv;
  logic signed [31:0] hh = 32'h000003E8, h = 32'h00000032, l = 32'h000000C8, ll = 32'hFFFFFC18;
  logic signed [31:0] rhh = 32'sh7FFFFFFF, rh = 32'sh7FFFFFFF;
  logic signed [31:0] rl = 32'sh80000000, rll = 32'sh80000000;
  int n;
  logic [31:0] raw_sample;
  logic [3:0] pva, rva;
  logic raw_valid, uei, cje, ie, ce, tick;
  int fails = 0, checks = 0;
  always #10 core_clk = ~core_clk;
  pac_ctl_model i_ctl (.core_clk, .odd_req, .raw_sample, .raw_valid, .exp_set_addr, .exp_ctl_addr);
  pac_core #(.PERIOD_HIRES_CYC(20), .PERIOD_NORM_CYC(10), .RATE_ALARMS(1'b1)) i_dut (.core_clk,
    .rst, .restart, .raw_sample, .raw_valid, .adc_fail, .input_fault, .cj_active, .init_hires,
    .init_avg_log2, .init_sqrt_en, .exp_set_addr, .exp_ctl_addr, .scale_max(smin + 32'sh3E8),
    .scale_min(smin), .scale_offset(soff), .span_gain, .pv_limit_hh(hh), .pv_limit_h(h),
    .pv_limit_l(l), .pv_limit_ll(ll), .roc_limit_hh(rhh), .roc_limit_h(rh),
    .roc_limit_l(rl), .roc_limit_ll(rll), .hysteresis, .on_delay,
    .off_delay, .process_value(pv), .rate_value(rv), .pv_alarm(pva), .roc_alarm(rva),
    .unit_error_indicator(uei), .cold_junction_error(cje), .input_error(ie),
    .converter_error(ce), .period_tick(tick));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // cycles from one tick to the next
  task automatic tick_gap(output int cnt);
    cnt = 0;
    while (tick !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    while (tick !== 1'b1) begin
      cnt++;
      @(negedge core_clk);
    end
    cnt++;
  endtask : tick_gap
  // zero gain pins the result at min plus offset, so min steers the value
  task automatic set_pv(input logic [31:0] v, input logic [3:0] exp);
    smin = v - soff;
    repeat (2) begin
      @(negedge core_clk);
      for (int k = 0; k < 40 && tick !== 1'b1; k++) @(negedge core_clk);
    end
    chk(pv, v);
    chk(pva, exp);
  endtask : set_pv
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    restart = 1'b1;
    @(negedge core_clk);
    restart = 1'b0;
    set_pv(32'h00000069, 4'h6);
    hysteresis = 16'h000A;
    h = 32'h0000006E;
    set_pv(32'h00000069, 4'h6);
    set_pv(32'h00000063, 4'h4);
    l = 32'h00000060;
    set_pv(32'h00000063, 4'h4);
    set_pv(32'h0000006C, 4'h0);
    set_pv(32'h0000012C, 4'h2);
    set_pv(32'h000007D0, 4'h3);
    rhh = 32'shFFFFFFFF;
    rl = 32'sh00000001;
    set_pv(32'hFFFFF830, 4'hC);
    chk(rva, 4'h5);
    init_hires = 1'b1;
    tick_gap(n);
    chk(n, 32'h0000000A);
    restart = 1'b1;
    @(negedge core_clk);
    restart = 1'b0;
    tick_gap(n);
    chk(n, 32'h00000014);
    {odd_req, input_fault, adc_fail, cj_active} = 4'hE;
    repeat (3) @(negedge core_clk);
    chk({uei, cje, ie, ce}, 4'hF);
    {odd_req, input_fault, adc_fail, cj_active} = 4'h1;
    repeat (8) @(negedge core_clk);
    chk({uei, cje, ie, ce}, 4'h0);
    stop_test();
  end
endmodule : pac_core_bench

// [bench/pac_ctl_model.sv]
// controller side model: sample feed and area addresses
`timescale 1ns/1ps
module pac_ctl_model (
  input wire logic core_clk,
  input wire logic odd_req,
  output logic [31:0] raw_sample,
  output logic raw_valid,
  output logic [15:0] exp_set_addr,
  output logic [15:0] exp_ctl_addr
);
  logic [1:0] cnt_ff = 2'h0;
  // start addresses stay even unless a fault is commanded
  assign exp_set_addr = {15'h0100, odd_req};
  assign exp_ctl_addr = 16'h0200;
  assign raw_valid = (cnt_ff == 2'h3);
  assign raw_sample = {30'h400, cnt_ff};
  always @(negedge core_clk) begin
    cnt_ff <= cnt_ff + 2'h1;
  end
endmodule : pac_ctl_model

// [hw/pac_core.sv]
// single channel conversion path with four level limit alarms
`timescale 1ns/1ps
module pac_core import pac_pkg::*; #(
  parameter int unsigned PERIOD_HIRES_CYC = PAC_PERIOD_HIRES_CYC,
  parameter int unsigned PERIOD_NORM_CYC = PAC_PERIOD_NORM_CYC,
  parameter bit RATE_ALARMS = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [31:0] raw_sample,
  input wire logic raw_valid,
  input wire logic adc_fail,
  input wire logic input_fault,
  input wire logic cj_active,
  input wire logic init_hires,
  input wire logic [2:0] init_avg_log2,
  input wire logic init_sqrt_en,
  input wire logic [15:0] exp_set_addr,
  input wire logic [15:0] exp_ctl_addr,
  input wire logic signed [31:0] scale_max,
  input wire logic signed [31:0] scale_min,
  input wire logic signed [31:0] scale_offset,
  input wire logic [15:0] span_gain,
  input wire logic signed [31:0] pv_limit_hh,
  input wire logic signed [31:0] pv_limit_h,
  input wire logic signed [31:0] pv_limit_l,
  input wire logic signed [31:0] pv_limit_ll,
  input wire logic signed [31:0] roc_limit_hh,
  input wire logic signed [31:0] roc_limit_h,
  input wire logic signed [31:0] roc_limit_l,
  input wire logic signed [31:0] roc_limit_ll,
  input wire logic [15:0] hysteresis,
  input wire logic [15:0] on_delay,
  input wire logic [15:0] off_delay,
  output logic signed [31:0] process_value,
  output logic signed [31:0] rate_value,
  output logic [3:0] pv_alarm,
  output logic [3:0] roc_alarm,
  output logic unit_error_indicator,
  output logic cold_junction_error,
  output logic input_error,
  output logic converter_error,
  output logic period_tick
);
  localparam int unsigned NA = 1 << PAC_AVG_MAX_LOG2;

  if (PERIOD_HIRES_CYC < 2) begin : g_bad_hires
    $error("hires period too short");
  end
  if (PERIOD_NORM_CYC < 2) begin : g_bad_norm
    $error("normal period too short");
  end
  if (PAC_AVG_MAX_LOG2 > 7) begin : g_bad_avg
    $error("average depth too large");
  end

  typedef struct packed {
    logic [31:0] tmr;
    logic hires;
    logic [2:0] avg_log2;
    logic sqrt_en;
    logic [NA-1:0][31:0] avg_buf;
    logic [PAC_AVG_MAX_LOG2-1:0] avg_idx;
    logic [31:0] latest;
    logic signed [31:0] pv;
    logic signed [31:0] pv_prev;
    logic signed [31:0] rv;
    logic [7:0] alm;
    logic [7:0][15:0] dly;
    logic uei;
    logic cje;
    logic ine;
    logic cve;
    logic tick;
  } pac_state_t;

  pac_state_t cur_ff;
  pac_state_t nxt_st;

  function automatic logic [31:0] pac_isqrt(input logic [31:0] v);
    logic [31:0] r;
    logic [31:0] b;
    logic [31:0] x;
    r = '0;
    b = 32'h40000000;
    x = v;
    for (int i = 0; i < 16; i++) begin
      if (x >= (r | b)) begin
        x = x - (r | b);
        r = (r >> 1) | b;
      end else begin
        r = r >> 1;
      end
      b = b >> 2;
    end
    return r << 8;
  endfunction : pac_isqrt

  logic [36:0] avg_sum;
  logic [31:0] avg_val;
  logic [31:0] root_val;
  logic signed [63:0] span_prod;
  logic signed [63:0] scaled;
  logic signed [31:0] new_pv;
  logic signed [31:0] new_rv;
  logic signed [7:0][31:0] lims;
  logic [31:0] reload_cyc;
  logic odd_addr;
  logic narrow_span;
  logic bad_avg;
  logic bad_setting;
  wire logic [7:0] step_alm;
  wire logic [7:0][15:0] step_dly;

  always_comb begin
    nxt_st = cur_ff;
    nxt_st.tick = 1'b0;
    avg_sum = '0;
    for (int i = 0; i < NA; i++) begin
      if (i < (1 << cur_ff.avg_log2)) begin
        avg_sum = avg_sum + {5'h00, cur_ff.avg_buf[i]};
      end
    end
    avg_val = 32'(avg_sum >> cur_ff.avg_log2);
    root_val = cur_ff.sqrt_en ? pac_isqrt(avg_val) : avg_val;
    // zero gain yields a constant result regardless of input
    span_prod = $signed({32'h00000000, root_val}) * $signed({48'h0, span_gain});
    // value from 0 to 2^32 maps to min..max; equal bounds give constant
    scaled = 64'(scale_min) + ((span_prod >>> 16) * 64'(scale_max - scale_min) >>> 32);
    new_pv = 32'(scaled + 64'(scale_offset));
    new_rv = new_pv - cur_ff.pv;
    odd_addr = exp_set_addr[0] | exp_ctl_addr[0];
    // either sign of span counts, so swapped bounds stay legal
    narrow_span = (32'(scale_max - scale_min) < PAC_SPAN_MIN)
      || (32'(scale_min - scale_max) < PAC_SPAN_MIN);
    bad_avg = init_avg_log2 > 3'(PAC_AVG_MAX_LOG2);
    bad_setting = odd_addr | narrow_span | bad_avg;
    nxt_st.uei = bad_setting;
    nxt_st.cje = ~cj_active;
    nxt_st.ine = input_fault;
    // a failure wins over a good sample in the same cycle
    if (adc_fail) begin
      nxt_st.cve = 1'b1;
    end else if (raw_valid) begin
      nxt_st.cve = 1'b0;
    end
    if (raw_valid && !adc_fail) begin
      nxt_st.latest = raw_sample;
    end
    lims[0] = pv_limit_hh;
    lims[1] = pv_limit_h;
    lims[2] = pv_limit_l;
    lims[3] = pv_limit_ll;
    lims[4] = roc_limit_hh;
    lims[5] = roc_limit_h;
    lims[6] = roc_limit_l;
    lims[7] = roc_limit_ll;
    reload_cyc = cur_ff.hires ? PERIOD_HIRES_CYC : PERIOD_NORM_CYC;
    // restart skips the evaluation so no tick follows a stale setting
    if (!restart && cur_ff.tmr == 32'h0) begin
      // one conversion per period; alarms see only that value
      nxt_st.tmr = reload_cyc - 32'h1;
      nxt_st.tick = 1'b1;
      nxt_st.avg_buf[cur_ff.avg_idx] = cur_ff.latest;
      nxt_st.avg_idx = PAC_AVG_MAX_LOG2'((cur_ff.avg_idx + 1'b1) & ((1 << cur_ff.avg_log2) - 1));
      nxt_st.pv = new_pv;
      nxt_st.rv = new_rv;
      nxt_st.alm = step_alm;
      nxt_st.dly = step_dly;
    end else begin
      nxt_st.tmr = cur_ff.tmr - 32'h1;
    end
    // initial settings only take effect at restart
    if (restart) begin
      nxt_st.hires = init_hires;
      nxt_st.avg_log2 = (init_avg_log2 > 3'(PAC_AVG_MAX_LOG2)) ? '0 : init_avg_log2;
      nxt_st.sqrt_en = init_sqrt_en;
      nxt_st.avg_idx = '0;
      nxt_st.tmr = '0;
    end
  end

  // one comparator per alarm; rate alarms sit in the upper four
  for (genvar k = 0; k < 8; k++) begin : g_alm
    pac_alarm_step i_step (
      .hi_side((k % 4) < 2),
      .enable(k < 4 || RATE_ALARMS),
      .value(k < 4 ? new_pv : new_rv),
      .limit(lims[k]),
      .hysteresis(hysteresis),
      .on_delay(on_delay),
      .off_delay(off_delay),
      .alm_ff(cur_ff.alm[k]),
      .dly_ff(cur_ff.dly[k]),
      .nxt_alm(step_alm[k]),
      .nxt_dly(step_dly[k])
    );
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign process_value = cur_ff.pv;
  assign rate_value = cur_ff.rv;
  assign pv_alarm = cur_ff.alm[3:0];
  assign roc_alarm = cur_ff.alm[7:4];
  assign unit_error_indicator = cur_ff.uei;
  assign cold_junction_error = cur_ff.cje;
  assign input_error = cur_ff.ine;
  assign converter_error = cur_ff.cve;
  assign period_tick = cur_ff.tick;
endmodule : pac_core

// one limit comparator with hysteresis and on/off delay counting
module pac_alarm_step import pac_pkg::*; (
  input wire logic hi_side,
  input wire logic enable,
  input wire logic signed [31:0] value,
  input wire logic signed [31:0] limit,
  input wire logic [15:0] hysteresis,
  input wire logic [15:0] on_delay,
  input wire logic [15:0] off_delay,
  input wire logic alm_ff,
  input wire logic [15:0] dly_ff,
  output logic nxt_alm,
  output logic [15:0] nxt_dly
);
  logic signed [32:0] val_ext;
  logic signed [32:0] lim_ext;
  logic signed [32:0] hys_ext;
  logic on_c;
  logic off_c;

  // 33 bits so limit plus hysteresis cannot wrap
  always_comb begin
    val_ext = 33'(value);
    lim_ext = 33'(limit);
    hys_ext = $signed({17'h0, hysteresis});
    // each alarm compares only to its own limit
    if (hi_side) begin
      on_c = val_ext > lim_ext;
      off_c = val_ext < lim_ext - hys_ext;
    end else begin
      on_c = val_ext < lim_ext;
      off_c = val_ext > lim_ext + hys_ext;
    end
    nxt_alm = alm_ff;
    nxt_dly = dly_ff;
    if (!enable) begin
      nxt_alm = 1'b0;
      nxt_dly = '0;
    end else if (!alm_ff) begin
      if (!on_c) begin
        nxt_dly = '0;
      end else if (dly_ff >= on_delay) begin
        nxt_alm = 1'b1;
        nxt_dly = '0;
      end else begin
        nxt_dly = dly_ff + 16'h0001;
      end
    end else begin
      // held until off condition lasts through the off delay
      if (!off_c) begin
        nxt_dly = '0;
      end else if (dly_ff >= off_delay) begin
        nxt_alm = 1'b0;
        nxt_dly = '0;
      end else begin
        nxt_dly = dly_ff + 16'h0001;
      end
    end
  end
endmodule : pac_alarm_step

// [hw/pac_pkg.sv]
// package for process alarm and conversion checks
package pac_pkg;
  localparam int unsigned PAC_CLK_HZ = 50000000;
  localparam int unsigned PAC_PERIOD_HIRES_MS = 60;
  localparam int unsigned PAC_PERIOD_HIRES_CYC = PAC_PERIOD_HIRES_MS * (PAC_CLK_HZ / 1000);
  localparam int unsigned PAC_PERIOD_NORM_MS = 10;
  localparam int unsigned PAC_PERIOD_NORM_CYC = PAC_PERIOD_NORM_MS * (PAC_CLK_HZ / 1000);
  localparam int unsigned PAC_DW = 32;
  localparam int unsigned PAC_AVG_MAX_LOG2 = 4;
  localparam int unsigned PAC_ALM_HH = 0;
  localparam int unsigned PAC_ALM_H = 1;
  localparam int unsigned PAC_ALM_L = 2;
  localparam int unsigned PAC_ALM_LL = 3;
  localparam logic [31:0] PAC_SPAN_MIN = 32'h00000004;
endpackage : pac_pkg
